// *** rtl/rx_slip_buffer_interrupts.sv ***
`timescale 1ns/10ps
`default_nettype none
module rx_slip_buffer_interrupts #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // slip buffer side
  input  wire logic              rx_write,
  input  wire logic              rx_full,
  input  wire logic              bp_read,
  input  wire logic              rx_empty,
  output logic                   drop_frame,
  output logic                   repeat_frame,
  // interrupt
  output logic                   irq
);

  // the decode needs the full index width
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 14 and 32");
  end

  // decode a byte address into a register select
  function automatic slip_irq_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(slip_irq_pkg::IDX_IRQ_EN)) begin
      decode = slip_irq_pkg::SEL_EN;
    end else if (idx == (ADDR_W-2)'(slip_irq_pkg::IDX_STATUS)) begin
      decode = slip_irq_pkg::SEL_STATUS;
    end else if (idx == (ADDR_W-2)'(slip_irq_pkg::IDX_COUNTS)) begin
      decode = slip_irq_pkg::SEL_COUNTS;
    end else begin
      decode = slip_irq_pkg::SEL_NONE;
    end
  endfunction : decode

  // write channel state
  logic              aw_held_r, aw_held_nxt;
  logic              w_held_r,  w_held_nxt;
  logic [ADDR_W-1:0] waddr_r,   waddr_nxt;
  logic [31:0]       wdata_r,   wdata_nxt;
  logic              wlane_r,   wlane_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r,  wready_nxt;
  logic              bvalid_r,  bvalid_nxt;
  logic [1:0]        bresp_r,   bresp_nxt;
  // read channel state
  logic              arready_r, arready_nxt;
  logic              rvalid_r,  rvalid_nxt;
  logic [31:0]       rdata_r,   rdata_nxt;
  logic [1:0]        rresp_r,   rresp_nxt;
  // register file and slip state
  logic [2:0]        en_r,      en_nxt;
  logic [2:0]        status_r,  status_nxt;
  logic [7:0]        ovf_cnt_r, ovf_cnt_nxt;
  logic [7:0]        unf_cnt_r, unf_cnt_nxt;
  logic              drop_r,    drop_nxt;
  logic              rep_r,     rep_nxt;
  logic              irq_r,     irq_nxt;
  // shared strobes
  logic              wr_do;
  logic              rd_do;
  logic              overflow;
  logic              underflow;
  logic [2:0]        set_bits;
  logic [2:0]        clr_bits;
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic              wl;
  slip_irq_pkg::reg_sel_t wsel;
  slip_irq_pkg::reg_sel_t rsel;

  // slip events, independent of any enable
  assign overflow  = rx_write & rx_full;
  assign underflow = bp_read & rx_empty;

  // write channel: address and data taken in either order
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wr_do       = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wlane_nxt  = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    wa   = waddr_nxt;
    wd   = wdata_nxt;
    wl   = wlane_nxt;
    wsel = decode(wa);
    if (aw_held_nxt && w_held_nxt && !bvalid_r) begin
      wr_do       = 1'b1;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wsel == slip_irq_pkg::SEL_NONE) ? slip_irq_pkg::RESP_SLVERR
                                                     : slip_irq_pkg::RESP_OKAY;
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  // read channel: one read at a time, answer on the next edge
  always_comb begin
    arready_nxt = !rvalid_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    rd_do       = 1'b0;
    rsel        = decode(s_axi_araddr);
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      rd_do       = 1'b1;
      rvalid_nxt  = 1'b1;
      arready_nxt = 1'b0;
      rresp_nxt   = slip_irq_pkg::RESP_OKAY;
      unique case (rsel)
        slip_irq_pkg::SEL_EN:     rdata_nxt = {29'h0, en_r};
        slip_irq_pkg::SEL_STATUS: rdata_nxt = {29'h0, status_r};
        slip_irq_pkg::SEL_COUNTS: rdata_nxt = {16'h0, unf_cnt_r, ovf_cnt_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = slip_irq_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // enables, sticky status, counters, slip actions and interrupt
  always_comb begin
    en_nxt   = en_r;
    clr_bits = 3'h0;
    if (wr_do && wl && wsel == slip_irq_pkg::SEL_EN) begin
      en_nxt = wd[2:0];
    end
    if (wr_do && wl && wsel == slip_irq_pkg::SEL_STATUS) begin
      clr_bits = wd[2:0];
    end
    set_bits                        = 3'h0;
    set_bits[slip_irq_pkg::BIT_FULL]  = overflow;
    set_bits[slip_irq_pkg::BIT_EMPTY] = underflow;
    set_bits[slip_irq_pkg::BIT_SLIP]  = overflow | underflow;
    // a set arriving with its clear wins
    status_nxt  = (status_r & ~clr_bits) | set_bits;
    ovf_cnt_nxt = (overflow && ovf_cnt_r != slip_irq_pkg::CNT_MAX) ? ovf_cnt_r + 8'h01
                                                                   : ovf_cnt_r;
    unf_cnt_nxt = (underflow && unf_cnt_r != slip_irq_pkg::CNT_MAX) ? unf_cnt_r + 8'h01
                                                                    : unf_cnt_r;
    drop_nxt = overflow;
    rep_nxt  = underflow;
    irq_nxt  = |(status_nxt & en_nxt);
  end

  // register all state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= 32'h0;
      wlane_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= slip_irq_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= slip_irq_pkg::RESP_OKAY;
      en_r      <= slip_irq_pkg::EN_RST;
      status_r  <= slip_irq_pkg::STATUS_RST;
      ovf_cnt_r <= slip_irq_pkg::CNT_RST;
      unf_cnt_r <= slip_irq_pkg::CNT_RST;
      drop_r    <= 1'b0;
      rep_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wlane_r   <= wlane_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      en_r      <= en_nxt;
      status_r  <= status_nxt;
      ovf_cnt_r <= ovf_cnt_nxt;
      unf_cnt_r <= unf_cnt_nxt;
      drop_r    <= drop_nxt;
      rep_r     <= rep_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign drop_frame    = drop_r;
  assign repeat_frame  = rep_r;
  assign irq           = irq_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ovf;
    rx_write && rx_full;
  endsequence
  sequence s_unf;
    bp_read && rx_empty;
  endsequence

  a_full_enable: assert property ($rose(en_r[2]) |-> $past(wr_do && wl))
    else $error("overflow enable changed without a register write");
  a_full_flag: assert property (s_ovf |=> status_r[2] && drop_frame)
    else $error("overflow did not set full flag and drop a frame");
  a_empty_enable: assert property ($fell(en_r[1]) |-> $past(wr_do && wl))
    else $error("underflow enable changed without a register write");
  a_empty_flag: assert property (s_unf |=> status_r[1] && repeat_frame)
    else $error("underflow did not set empty flag and repeat a frame");
  a_slip_irq: assert property (en_r[0] && status_r[0] |-> irq)
    else $error("enabled slip flag did not raise the interrupt");
  a_slip_flag: assert property (s_ovf or s_unf |=> status_r[0])
    else $error("slip flag not set after a drop or repeat");
  a_slip_action: assert property ((en_r == 3'h0 && !wr_do) and s_ovf
    |=> drop_frame ##0 !irq)
    else $error("frame drop must happen with interrupts disabled");
  a_irq_cause: assert property (irq |-> |(status_r & en_r))
    else $error("interrupt high without an enabled status flag");
  a_bresp_hold: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before acceptance");

  // answer timing, one-cycle slip pulses, sticky flags and the overflow counter
  a_write_answer: assert property (wr_do |=> s_axi_bvalid)
    else $error("write response missing after a register write");
  a_read_answer: assert property (rd_do |=> s_axi_rvalid)
    else $error("read data missing after a read request");
  a_drop_pulse: assert property (!(rx_write && rx_full) |=> !drop_frame)
    else $error("frame drop without an overflow");
  a_repeat_pulse: assert property (!(bp_read && rx_empty) |=> !repeat_frame)
    else $error("frame repeat without an underflow");
  a_full_sticky: assert property (status_r[2] && !clr_bits[2] |=> status_r[2])
    else $error("full flag cleared without a write of one");
  a_empty_sticky: assert property (status_r[1] && !clr_bits[1] |=> status_r[1])
    else $error("empty flag cleared without a write of one");
  a_slip_sticky: assert property (status_r[0] && !clr_bits[0] |=> status_r[0])
    else $error("slip flag cleared without a write of one");
  a_ovf_count: assert property (overflow && ovf_cnt_r != slip_irq_pkg::CNT_MAX
    |=> ovf_cnt_r == $past(ovf_cnt_r) + 8'h01)
    else $error("overflow count did not advance");

endmodule : rx_slip_buffer_interrupts
`default_nettype wire

// *** rtl/slip_irq_pkg.sv ***
// Summary of operation
// - bit 2 enables the receive overflow interrupt, read/write, resets to 0.
// - write into a full buffer drops one frame and sets the full status flag.
// - bit 1 enables the receive underflow interrupt, read/write, resets to 0.
// - read from an empty buffer repeats one frame and sets the empty status flag.
// - bit 0 enables the interrupt for any slip, full or empty, resets to 0.
// - slip status flag sets on either a frame drop or a frame repeat.
package slip_irq_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_IRQ_EN   = 12'hb09;
  localparam logic [11:0] IDX_STATUS   = 12'hb20;
  localparam logic [11:0] IDX_COUNTS   = 12'hb21;
  // field positions, shared by enable and status
  localparam int BIT_FULL  = 2;
  localparam int BIT_EMPTY = 1;
  localparam int BIT_SLIP  = 0;
  localparam int NFLAGS    = 3;
  // reset values
  localparam logic [2:0] EN_RST     = 3'h0;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register select codes
  typedef enum logic [3:0] {
    SEL_NONE   = 4'h1,
    SEL_EN     = 4'h2,
    SEL_STATUS = 4'h4,
    SEL_COUNTS = 4'h8
  } reg_sel_t;
endpackage : slip_irq_pkg

// *** dv/slip_side_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// elastic store seen from the framer write side and the backplane read side
module slip_side_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // requests from the bench
  input  wire logic wr_req,
  input  wire logic rd_req,
  // buffer side of the block
  output logic      rx_write,
  output logic      rx_full,
  output logic      bp_read,
  output logic      rx_empty
);
  int lvl_r;
  int lvl_nxt;
  // strobes pass straight through, flags follow the fill level
  assign rx_write = wr_req;
  assign bp_read  = rd_req;
  assign rx_full  = (lvl_r == DEPTH);
  assign rx_empty = (lvl_r == 0);
  // a slip leaves the fill level where it was
  always_comb begin
    lvl_nxt = lvl_r;
    if (wr_req && !rx_full) lvl_nxt = lvl_nxt + 1;
    if (rd_req && !rx_empty) lvl_nxt = lvl_nxt - 1;
  end
  always_ff @(posedge clk) begin
    lvl_r <= sys_rst ? 0 : lvl_nxt;
  end
endmodule : slip_side_model
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [15:0] A_EN  = 16'({slip_irq_pkg::IDX_IRQ_EN, 2'h0});
  localparam logic [15:0] A_ST  = 16'({slip_irq_pkg::IDX_STATUS, 2'h0});
  localparam logic [15:0] A_BAD = 16'h2c28;
  localparam logic [15:0] A_CNT = 16'({slip_irq_pkg::IDX_COUNTS, 2'h0});
  logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wr_req, rd_req;
  logic        rx_write, rx_full, bp_read, rx_empty, drop_frame, repeat_frame, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  int          failures, n_compared;
  rx_slip_buffer_interrupts rx_slip_buffer_interrupts_i (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_write(rx_write), .rx_full(rx_full), .bp_read(bp_read), .rx_empty(rx_empty),
    .drop_frame(drop_frame), .repeat_frame(repeat_frame), .irq(irq));
  slip_side_model slip_side_model_i (.clk(clk), .sys_rst(sys_rst), .wr_req(wr_req),
    .rd_req(rd_req), .rx_write(rx_write), .rx_full(rx_full), .bp_read(bp_read),
    .rx_empty(rx_empty));
  // 100 ns clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // write one word, holding each channel until it is taken
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] xr);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb === 1'h1) begin
        bready <= 1'h0;
        chk(32'(bresp), 32'(xr));
        return;
      end
    end
    chk(32'h0, 32'h1);
    end_of_test();
  endtask : axi_wr
  // read one word and compare data and response
  task automatic axi_rd(input logic [15:0] a, input logic [31:0] xd, input logic [1:0] xr);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tr === 1'h1) begin
        rready <= 1'h0;
        chk(rdata, xd);
        chk(32'(rresp), 32'(xr));
        return;
      end
    end
    chk(32'h0, 32'h1);
    end_of_test();
  endtask : axi_rd
  // one buffer access; x holds the expected drop, repeat and irq
  task automatic ev(input logic w, input logic r, input logic [2:0] x);
    @(posedge clk);
    wr_req <= w;
    rd_req <= r;
    @(posedge clk);
    wr_req <= 1'h0;
    rd_req <= 1'h0;
    @(negedge clk);
    chk(32'({drop_frame, repeat_frame, irq}), 32'(x));
    @(negedge clk);
    chk(32'({drop_frame, repeat_frame}), 32'h0);
  endtask : ev
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask : irq_is
  task automatic t_regs;
    axi_rd(A_EN, 32'h0, 2'h0);
    axi_rd(A_ST, 32'h0, 2'h0);
    for (int b = 0; b < 3; b++) begin
      axi_wr(A_EN, 32'h1 << b, 2'h0);
      axi_rd(A_EN, 32'h1 << b, 2'h0);
      irq_is(1'h0);
    end
    axi_wr(A_BAD, 32'h7, 2'h2);
    axi_rd(A_BAD, 32'h0, 2'h2);
    // a write without byte lane 0 leaves the enables alone
    wstrb <= 4'he;
    axi_wr(A_EN, 32'h7, 2'h0);
    axi_rd(A_EN, 32'h4, 2'h0);
    wstrb <= 4'hf;
    axi_wr(A_EN, 32'h0, 2'h0);
    $display("test registers done");
  endtask : t_regs
  task automatic t_overflow;
    ev(1'h1, 1'h0, 3'h0);
    ev(1'h1, 1'h0, 3'h0);
    ev(1'h1, 1'h0, 3'h4);
    axi_rd(A_ST, 32'h5, 2'h0);
    axi_wr(A_EN, 32'h2, 2'h0);
    irq_is(1'h0);
    axi_wr(A_EN, 32'h4, 2'h0);
    irq_is(1'h1);
    axi_wr(A_EN, 32'h1, 2'h0);
    irq_is(1'h1);
    axi_wr(A_ST, 32'h7, 2'h0);
    irq_is(1'h0);
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_underflow;
    ev(1'h0, 1'h1, 3'h0);
    ev(1'h0, 1'h1, 3'h0);
    ev(1'h0, 1'h1, 3'h3);
    axi_rd(A_ST, 32'h3, 2'h0);
    axi_wr(A_EN, 32'h2, 2'h0);
    irq_is(1'h1);
    axi_wr(A_EN, 32'h4, 2'h0);
    irq_is(1'h0);
    axi_wr(A_EN, 32'h0, 2'h0);
    ev(1'h0, 1'h1, 3'h2);
    axi_wr(A_ST, 32'h7, 2'h0);
    axi_rd(A_ST, 32'h0, 2'h0);
    axi_rd(A_CNT, 32'h0000_0201, 2'h0);
    $display("test underflow done");
  endtask : t_underflow
  // reset, then the scenarios in turn
  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready, wr_req, rd_req} = 8'h80;
    {awaddr, araddr, wdata} = 64'h0;
    wstrb = 4'hf;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs();
    t_overflow();
    t_underflow();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
